// [rtl/adcrb_consts.vh]
/*
 register offsets, field positions, reset values and timing counts
 for the converter control register bank; included by the design file.
*/
`ifndef ADCRB_CONSTS_VH
`define ADCRB_CONSTS_VH

// byte offsets on the register bus
`define ADCRB_OFF_CTRL 12'h000
`define ADCRB_OFF_SRC 12'h004
`define ADCRB_OFF_AMP 12'h008
`define ADCRB_OFF_BG 12'h00C
`define ADCRB_OFF_RES_HI 12'h010
`define ADCRB_OFF_RES_LO 12'h014

// conv_ctrl_channel fields
`define ADCRB_START_BIT 7
`define ADCRB_BUSY_BIT 6
`define ADCRB_EN_BIT 5
`define ADCRB_JUST_BIT 4
// input_source_clock_sel fields
`define ADCRB_SRC_HI 7
`define ADCRB_SRC_LO 4
// amp_reference_ctrl fields
`define ADCRB_AMPEN_BIT 7
`define ADCRB_AMPIN_BIT 4

// write masks of implemented bits
`define ADCRB_MASK_CTRL 8'hBF
`define ADCRB_MASK_SRC 8'hF7
`define ADCRB_MASK_AMP 8'h9F
`define ADCRB_MASK_BG 8'h01

`define ADCRB_RST_REG 8'h00

// conversion length in conversion-clock periods
`define ADCRB_CONV_CLKS 16

`endif

// [rtl/adcrb_bank.v]
/*
 converter control register bank: four control registers over apb,
 conversion sequencer, result formatting and analog select decode.
 assumes the analog converter delivers conv_data while a conversion
 runs and that core_clk is the system clock.
*/
// The register addresses and the APB interface to the registers were decided locally.
`include "adcrb_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module adcrb_bank #(
   parameter CONV_CLKS = `ADCRB_CONV_CLKS,
   parameter PIN_COUNT = 9
) (
   // clock and reset
   input wire core_clk,
   input wire arst_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // converter data and pin function
   input wire [11:0] conv_data,
   input wire [PIN_COUNT-1:0] pin_analog_sel,
   // converter control
   output reg converter_enable,
   output reg conv_sample,
   output reg conv_clk_en,
   output reg conv_irq,
   output reg [8:0] analog_input_pins,
   output reg ext_path_on,
   output reg [2:0] internal_tap,
   output reg input_ground,
   output reg [1:0] ref_route,
   output reg ref_pin_on,
   output reg amp_enable,
   output reg amp_ext_input_pin,
   output reg amp_bandgap_in,
   output reg [1:0] amp_gain_sel,
   output reg bandgap_enable,
   output reg [PIN_COUNT-1:0] pin_func_off,
   output reg [PIN_COUNT-1:0] pin_pullup_off
);

   reg start_bit;
   reg conv_busy_flag;
   reg result_justify_sel;
   reg [3:0] ext_channel_sel;
   reg [3:0] input_source_sel;
   reg [2:0] conv_clock_div_sel;
   reg amp_input_sel;
   reg [1:0] reference_sel;
   reg [7:0] result_high_byte;
   reg [7:0] result_low_byte;
   reg [6:0] div_cnt;
   reg [15:0] conv_cnt;
   reg [7:0] wbyte;
   reg [7:0] ctrl_rd;
   reg [7:0] src_rd;
   reg [7:0] amp_rd;
   reg mapped;
   reg [6:0] div_mask;
   reg [31:0] rd_mux;
   reg next_ext_path;
   reg [2:0] next_tap;
   reg next_ground;

   wire wr_en = psel & penable & pwrite;
   wire wr_ctrl = wr_en && (paddr == `ADCRB_OFF_CTRL);
   wire start_fall = wr_ctrl && start_bit && !pwdata[`ADCRB_START_BIT];
   wire tick = ((div_cnt & div_mask) == 7'h00);
   wire conv_done = conv_busy_flag && tick && (conv_cnt == 16'h0001);

   assign pready = 1'b1;
   assign pslverr = 1'b0;

   always @* begin
      wbyte = pwdata[7:0];
      div_mask = (7'h01 << conv_clock_div_sel) - 7'h01;
      mapped = 1'b1;
      ctrl_rd = {start_bit, conv_busy_flag, converter_enable, result_justify_sel,
                 ext_channel_sel};
      src_rd = {input_source_sel, 1'b0, conv_clock_div_sel};
      amp_rd = {amp_enable, 2'b00, amp_input_sel, reference_sel, amp_gain_sel};
      rd_mux = 32'h0000_0000;
      case (paddr)
         `ADCRB_OFF_CTRL: rd_mux[7:0] = ctrl_rd;
         `ADCRB_OFF_SRC: rd_mux[7:0] = src_rd;
         `ADCRB_OFF_AMP: rd_mux[7:0] = amp_rd;
         `ADCRB_OFF_BG: rd_mux[7:0] = {7'h00, bandgap_enable};
         `ADCRB_OFF_RES_HI: rd_mux[7:0] = result_high_byte;
         `ADCRB_OFF_RES_LO: rd_mux[7:0] = result_low_byte;
         default: mapped = 1'b0;
      endcase
      if (!mapped) begin
         rd_mux = 32'h0000_0000;
      end
   end

   // read data captured in the setup cycle, stands through the access phase
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   // control register writes
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         start_bit <= 1'b0;
         converter_enable <= 1'b0;
         result_justify_sel <= 1'b0;
         ext_channel_sel <= 4'h0;
         input_source_sel <= 4'h0;
         conv_clock_div_sel <= 3'h0;
         amp_enable <= 1'b0;
         amp_input_sel <= 1'b0;
         reference_sel <= 2'h0;
         amp_gain_sel <= 2'h0;
         bandgap_enable <= 1'b0;
      end else if (wr_en) begin
         case (paddr)
            `ADCRB_OFF_CTRL: begin
               start_bit <= wbyte[`ADCRB_START_BIT];
               converter_enable <= wbyte[`ADCRB_EN_BIT];
               result_justify_sel <= wbyte[`ADCRB_JUST_BIT];
               ext_channel_sel <= wbyte[3:0];
            end
            `ADCRB_OFF_SRC: begin
               input_source_sel <= wbyte[`ADCRB_SRC_HI:`ADCRB_SRC_LO];
               conv_clock_div_sel <= wbyte[2:0];
            end
            `ADCRB_OFF_AMP: begin
               amp_enable <= wbyte[`ADCRB_AMPEN_BIT];
               amp_input_sel <= wbyte[`ADCRB_AMPIN_BIT];
               reference_sel <= wbyte[3:2];
               amp_gain_sel <= wbyte[1:0];
            end
            `ADCRB_OFF_BG: bandgap_enable <= wbyte[0];
            default: begin
            end
         endcase
      end
   end

   // conversion sequencer
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_busy_flag <= 1'b0;
         div_cnt <= 7'h00;
         conv_cnt <= 16'h0000;
         result_high_byte <= `ADCRB_RST_REG;
         result_low_byte <= `ADCRB_RST_REG;
         conv_irq <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 7'h01;
         conv_irq <= 1'b0;
         if (!converter_enable) begin
            conv_busy_flag <= 1'b0;
         end else if (start_fall && !conv_busy_flag) begin
            conv_busy_flag <= 1'b1;
            conv_cnt <= CONV_CLKS[15:0];
            div_cnt <= 7'h01;
         end else if (conv_done) begin
            conv_busy_flag <= 1'b0;
            conv_irq <= 1'b1;
            if (result_justify_sel) begin
               result_high_byte <= {4'h0, conv_data[11:8]};
               result_low_byte <= conv_data[7:0];
            end else begin
               result_high_byte <= conv_data[11:4];
               result_low_byte <= {conv_data[3:0], 4'h0};
            end
         end else if (conv_busy_flag && tick) begin
            conv_cnt <= conv_cnt - 16'h0001;
         end
      end
   end

   // source decode: external path, supply taps, amplifier taps, ground
   always @* begin
      next_ext_path = 1'b0;
      next_tap = 3'h0;
      next_ground = 1'b0;
      case (input_source_sel)
         4'h0: next_ext_path = 1'b1;
         4'h1: next_tap = 3'h1;
         4'h2: next_tap = 3'h2;
         4'h3: next_tap = 3'h3;
         4'h4: next_ext_path = 1'b1;
         4'h5: next_tap = 3'h5;
         4'h6: next_tap = 3'h6;
         4'h7: next_tap = 3'h7;
         4'h8: next_ground = 1'b1;
         4'h9: next_ground = 1'b1;
         4'hA: next_ground = 1'b1;
         4'hB: next_ground = 1'b1;
         4'hC: next_ext_path = 1'b1;
         4'hD: next_ext_path = 1'b1;
         4'hE: next_ext_path = 1'b1;
         4'hF: next_ext_path = 1'b1;
         default: begin
            next_ext_path = 1'b0;
            next_tap = 3'h0;
            next_ground = 1'b0;
         end
      endcase
   end

   // one switch per external channel; codes above 8 leave all open
   genvar c;
   generate
      for (c = 0; c < 9; c = c + 1) begin : chan_gen
         localparam [3:0] CODE = c;
         always @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               analog_input_pins[c] <= 1'b0;
            end else begin
               analog_input_pins[c] <= next_ext_path && (ext_channel_sel == CODE);
            end
         end
      end
   endgenerate

   // analog select registers
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_sample <= 1'b0;
         conv_clk_en <= 1'b0;
         ext_path_on <= 1'b0;
         internal_tap <= 3'h0;
         input_ground <= 1'b0;
         ref_route <= 2'h0;
         ref_pin_on <= 1'b0;
         amp_ext_input_pin <= 1'b0;
         amp_bandgap_in <= 1'b0;
      end else begin
         conv_sample <= conv_busy_flag;
         conv_clk_en <= converter_enable & tick;
         input_ground <= next_ground;
         ext_path_on <= next_ext_path;
         internal_tap <= next_tap;
         ref_route <= reference_sel;
         ref_pin_on <= (reference_sel == 2'b01);
         amp_ext_input_pin <= !amp_input_sel;
         amp_bandgap_in <= amp_input_sel;
      end
   end

   // pin function takeover
   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g = g + 1) begin : pin_gen
         always @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               pin_func_off[g] <= 1'b0;
               pin_pullup_off[g] <= 1'b0;
            end else begin
               pin_func_off[g] <= pin_analog_sel[g];
               pin_pullup_off[g] <= pin_analog_sel[g];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// [verification/adcrb_conv_model.sv]
/* converter model: result level during sampling, noise elsewhere.
   assumes conv_sample marks the sampling window. */
`timescale 1ns/1ps
`default_nettype none
module adcrb_conv_model (
   // clock
   input wire logic core_clk,
   // converter side
   input wire logic sample,
   input wire logic [11:0] level,
   output wire logic [11:0] conv_data
);
   logic [11:0] junk = 12'h000;
   always @(posedge core_clk) begin
      junk <= junk + 12'h5a5;
   end
   // valid only while sampling
   assign conv_data = sample ? level : ~level ^ junk;
endmodule
`default_nettype wire

// [verification/adcrb_checker.sv]
/* port assertions for adcrb_bank.
   assumes one clock, reset active low. */
`timescale 1ns/1ps
`default_nettype none
module adcrb_checker (
   // clock, reset, bus
   input wire core_clk,
   input wire arst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   // controls
   input wire converter_enable,
   input wire conv_clk_en,
   input wire conv_irq,
   input wire [8:0] analog_input_pins,
   input wire ext_path_on,
   input wire [2:0] internal_tap,
   input wire input_ground,
   input wire [1:0] ref_route,
   input wire ref_pin_on,
   input wire amp_ext_input_pin,
   input wire amp_bandgap_in,
   input wire bandgap_enable,
   input wire [8:0] pin_func_off,
   input wire [8:0] pin_pullup_off
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   wire bg_wr = psel && penable && pwrite && paddr == 12'h00c;
   tap_cuts_ext_a: assert property (internal_tap != 3'd0 |->
      !ext_path_on && analog_input_pins == 9'h000) else $error("tap with ext path");
   ground_only_a: assert property (input_ground |->
      !ext_path_on && internal_tap == 3'd0) else $error("ground not alone");
   channel_onehot_a: assert property ($onehot0(analog_input_pins) &&
      (ext_path_on || analog_input_pins == 9'h000)) else $error("channel select");
   bandgap_drops_pin_a: assert property (amp_bandgap_in |->
      !amp_ext_input_pin) else $error("pin with bandgap");
   ref_pin_route_a: assert property (ref_pin_on ==
      (ref_route == 2'b01)) else $error("reference pin");
   irq_one_cycle_a: assert property (conv_irq |=> !conv_irq) else $error("irq");
   off_no_clock_a: assert property (!converter_enable [*2] |->
      !conv_clk_en && !conv_irq) else $error("clock while off");
   bandgap_write_a: assert property (bg_wr |=>
      bandgap_enable == $past(pwdata[0])) else $error("bandgap bit");
   pin_release_a: assert property (pin_func_off == pin_pullup_off)
      else $error("pin release");
   cover property (conv_irq);
   cover property (input_ground);
   cover property (amp_bandgap_in);
endmodule
bind adcrb_bank adcrb_checker i_adcrb_checker (.*);
`default_nettype wire

// [verification/adc_control_register_bank_test.sv]
/* apb bench for adcrb_bank.
   assumes the converter model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_bank_test;
   reg core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   reg [11:0] paddr = 0, level = 12'habc;
   reg [31:0] pwdata = 0, rd;
   reg [8:0] pin_sel = 0;
   wire pready, pslverr, conv_sample, conv_irq, ext_path_on, input_ground, ref_pin_on;
   wire amp_enable, amp_ext_input_pin, amp_bandgap_in, bandgap_enable;
   wire [31:0] prdata;
   wire [11:0] conv_data;
   wire [8:0] pins, func_off, pull_off;
   wire [2:0] tap;
   wire [1:0] ref_route, gain;
   integer failures = 0, comparisons = 0, n, i, e, g;
   adcrb_bank #(.CONV_CLKS(2)) i_adcrb_bank (.core_clk, .arst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .conv_data,
      .pin_analog_sel(pin_sel), .converter_enable(), .conv_sample, .conv_clk_en(),
      .conv_irq, .analog_input_pins(pins), .ext_path_on, .internal_tap(tap), .input_ground,
      .ref_route, .ref_pin_on, .amp_enable, .amp_ext_input_pin, .amp_bandgap_in,
      .amp_gain_sel(gain), .bandgap_enable, .pin_func_off(func_off), .pin_pullup_off(pull_off));
   adcrb_conv_model i_adcrb_conv_model (.core_clk, .sample(conv_sample), .level, .conv_data);
   initial forever #50 core_clk = ~core_clk;
   task check(input [31:0] seen, input [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("%0d compares, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task bound(input integer k);
      if (k >= 300) begin
         failures = failures + 1;
         print_verdict;
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge core_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      n = 0;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 300) begin
         n = n + 1;
         @(posedge core_clk);
      end
      rd = prdata;
      bound(n);
      psel <= 0;
      penable <= 0;
   endtask
   task rdc(input [11:0] a, input [31:0] x);
      apb(0, a, 0);
      check(rd, x);
   endtask
   task settle;
      repeat (2) @(negedge core_clk);
   endtask
   task wirq;
      n = 0;
      while (conv_irq !== 1'b1 && n < 300) begin
         n = n + 1;
         @(negedge core_clk);
      end
      bound(n);
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      arst_n <= 1;
      for (i = 0; i < 4; i = i + 1) rdc(12'(4 * i), 0);
      check({pready, pslverr}, 2);
      apb(1, 12'h00c, 8'hff);
      apb(1, 12'h004, 8'hff);
      apb(1, 12'h008, 8'hff);
      rdc(12'h004, 8'hf7);
      rdc(12'h008, 8'h9f);
      rdc(12'h00c, 8'h01);
      rdc(12'h020, 0);
      check(bandgap_enable, 1);
      for (i = 0; i < 4; i = i + 1) begin
         apb(1, 12'h008, 128 + (i % 2) * 16 + i * 5);
         settle;
         check(amp_bandgap_in, i % 2);
         check(amp_ext_input_pin, 1 - i % 2);
         check({ref_pin_on, ref_route}, i + (i == 1) * 4);
         check({amp_enable, gain}, 4 + i);
      end
      apb(1, 12'h008, 0);
      apb(1, 12'h000, 3);
      for (i = 0; i < 16; i = i + 1) begin
         apb(1, 12'h004, i * 16);
         settle;
         e = i == 0 || i == 4 || i >= 12;
         g = i / 4 == 2;
         check(ext_path_on, e);
         check(input_ground, g);
         check(tap, (e || g) ? 0 : i % 8);
         check(pins, e * 8);
      end
      apb(1, 12'h004, 0);
      apb(1, 12'h000, 9);
      pin_sel <= 9'h155;
      settle;
      check(pins, 0);
      check(func_off & pull_off, 9'h155);
      $display("select tests done");
      apb(1, 12'h004, 3);
      apb(1, 12'h000, 8'ha0);
      apb(1, 12'h000, 8'h20);
      rdc(12'h000, 8'h60);
      wirq;
      check(n >= 10 && n <= 24, 1);
      rdc(12'h010, 8'hab);
      rdc(12'h014, 8'hc0);
      rdc(12'h000, 8'h20);
      apb(1, 12'h004, 0);
      apb(1, 12'h000, 8'hb0);
      apb(1, 12'h000, 8'h30);
      wirq;
      rdc(12'h010, 8'h0a);
      rdc(12'h014, 8'hbc);
      level <= 12'h123;
      apb(1, 12'h000, 0);
      apb(1, 12'h000, 8'h80);
      apb(1, 12'h000, 0);
      repeat (20) @(negedge core_clk);
      rdc(12'h010, 8'h0a);
      rdc(12'h014, 8'hbc);
      $display("conversion tests done");
      print_verdict;
   end
endmodule
`default_nettype wire
